// *** rtl/rx_front_end.sv ***
// Behaviour
// - Deserialise each channel's serial stream into 12-bit words.
// - Sign-extend each 12-bit sample to 16-bit two's complement for correction.
// - Apply selectable gain to I and Q, 0.5 dB steps, up to 18 dB.
// - Gain output passes interpolation by two, DC removal, then quadrature mixing.
// - Power of I and Q computed separately on the sample clock.
// - Accumulate over 2^19-sample windows four times, average to 32 bits.
// - Averaged power refreshed once every four windows.
// - Correction step size chosen automatically from measured power.
// - Gain taken from 43-entry table, -3 to +18 dB, index from software.
`timescale 1ns/1ps
module rx_front_end #(
	parameter int WIN_LOG2 = rx_fe_pkg::WIN_LOG2_DEF
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic adc_bit_valid,
	input wire logic adc_frame,
	input wire logic adc_bit_i,
	input wire logic adc_bit_q,
	output logic [15:0] sext_i,
	output logic [15:0] sext_q,
	output logic sext_valid,
	input wire logic [15:0] cor_i,
	input wire logic [15:0] cor_q,
	input wire logic cor_valid,
	input wire logic [5:0] gain_idx,
	input wire logic [31:0] thr_low,
	input wire logic [31:0] thr_mid,
	input wire logic [31:0] thr_high,
	output logic [3:0] step_size,
	output logic [31:0] pwr_i,
	output logic [31:0] pwr_q,
	output logic pwr_valid,
	output logic [15:0] dac_i,
	output logic [15:0] dac_q,
	output logic dac_valid
);
	localparam int ACC_W = rx_fe_pkg::PWR_W + WIN_LOG2;

	typedef struct packed {
		logic [1:0][15:0] sext;
		logic sext_v;
		logic [1:0][ACC_W-1:0] acc;
		logic [WIN_LOG2-1:0] wcnt;
		logic [1:0] slot;
		logic [1:0][33:0] msum;
		logic [1:0][31:0] pwr;
		logic pwr_v;
		logic [3:0] step;
		logic [1:0][15:0] g;
		logic g_v;
		logic [1:0][15:0] gprev;
		logic ip_pend;
		logic [1:0][15:0] ip;
		logic ip_v;
		logic [1:0][15:0] dcoff;
		logic [1:0] mix_ph;
		logic [1:0][15:0] dac;
		logic dac_v;
	} fe_t;

	fe_t st_q;
	fe_t st_d;

	logic [1:0][11:0] word;
	logic [1:0] word_v;

	genvar gc;
	generate
		for (gc = 0; gc < rx_fe_pkg::NUM_CH; gc++) begin : g_cap
			ser_word_capture u_cap (
				.core_clk(core_clk),
				.arst_n(arst_n),
				.bit_valid(adc_bit_valid),
				.frame(adc_frame),
				.ser_bit(gc == 0 ? adc_bit_i : adc_bit_q),
				.word(word[gc]),
				.word_valid(word_v[gc])
			);
		end
	endgenerate

	function automatic logic [15:0] sat16(input logic signed [16:0] v);
		if (v > 17'sh07FFF) begin
			sat16 = 16'h7FFF;
		end else if (v < -17'sh08000) begin
			sat16 = 16'h8000;
		end else begin
			sat16 = v[15:0];
		end
	endfunction : sat16

	function automatic logic [31:0] square(input logic [15:0] v);
		square = 32'($signed(v) * $signed(v));
	endfunction : square

	logic [5:0] gidx;
	logic [15:0] gval;
	logic [33:0] pavg;
	assign gidx = (gain_idx > rx_fe_pkg::GAIN_IDX_MAX) ? rx_fe_pkg::GAIN_IDX_MAX : gain_idx;
	assign gval = rx_fe_pkg::GAIN_LUT[gidx];

	always_comb begin
		logic [ACC_W-1:0] acc_n;
		logic [33:0] msum_n;
		logic signed [32:0] prod;
		logic signed [32:0] shp;
		logic [15:0] x;
		logic [15:0] y;
		logic [15:0] yi;
		logic [15:0] yq;
		logic [1:0][15:0] yv;
		acc_n = '0;
		msum_n = '0;
		prod = '0;
		shp = '0;
		x = '0;
		y = '0;
		yi = '0;
		yq = '0;
		yv = '0;
		st_d = st_q;
		st_d.sext_v = &word_v;
		st_d.pwr_v = 1'b0;
		st_d.g_v = 1'b0;
		st_d.ip_v = 1'b0;
		st_d.dac_v = 1'b0;
		for (int c = 0; c < rx_fe_pkg::NUM_CH; c++) begin
			if (&word_v) begin
				st_d.sext[c] = {{4{word[c][11]}}, word[c]};
			end
			if (cor_valid) begin
				prod = $signed(cor_valid ? (c == 0 ? cor_i : cor_q) : 16'h0000)
					* $signed({1'b0, gval});
				shp = prod >>> rx_fe_pkg::GAIN_FRAC;
				st_d.g[c] = (shp > 33'sh07FFF) ? 16'h7FFF :
					(shp < -33'sh08000) ? 16'h8000 : shp[15:0];
			end
			if (st_q.sext_v) begin
				// Window start reloads, otherwise accumulate the square
				acc_n = (st_q.wcnt == '0) ? ACC_W'(square(st_q.sext[c])) :
					st_q.acc[c] + ACC_W'(square(st_q.sext[c]));
				st_d.acc[c] = acc_n;
				if (st_q.wcnt == '1) begin
					msum_n = ((st_q.slot == 2'h0) ? 34'h0 : st_q.msum[c])
						+ 34'(acc_n >> WIN_LOG2);
					st_d.msum[c] = msum_n;
					if (st_q.slot == rx_fe_pkg::LAST_SLOT) begin
						st_d.pwr[c] = msum_n[33:2];
					end
				end
			end
			if (st_q.g_v) begin
				// First half-rate point is the midpoint with the previous sample
				st_d.ip[c] = sat16(17'(($signed(st_q.g[c]) + $signed(st_q.gprev[c])) >>> 1));
				st_d.gprev[c] = st_q.g[c];
			end else if (st_q.ip_pend) begin
				st_d.ip[c] = st_q.gprev[c];
			end
			if (st_q.ip_v) begin
				x = st_q.ip[c];
				y = sat16(17'($signed(x) - $signed(st_q.dcoff[c])));
				yv[c] = y;
				st_d.dcoff[c] = sat16(17'($signed(st_q.dcoff[c])
					+ ($signed(y) >>> rx_fe_pkg::DC_SHIFT)));
			end
		end
		if (st_q.sext_v) begin
			st_d.wcnt = st_q.wcnt + 1'b1;
			if (st_q.wcnt == '1) begin
				st_d.slot = st_q.slot + 2'h1;
				st_d.pwr_v = (st_q.slot == rx_fe_pkg::LAST_SLOT);
			end
		end
		// Automatic step size from the combined averaged power
		pavg = (34'(st_d.pwr[0]) + 34'(st_d.pwr[1])) >> 1;
		if (st_d.pwr_v) begin
			st_d.step = (pavg < 34'(thr_low)) ? rx_fe_pkg::STEP_TBL[0] :
				(pavg < 34'(thr_mid)) ? rx_fe_pkg::STEP_TBL[1] :
				(pavg < 34'(thr_high)) ? rx_fe_pkg::STEP_TBL[2] :
				rx_fe_pkg::STEP_TBL[3];
		end
		st_d.g_v = cor_valid;
		st_d.ip_v = st_q.g_v || st_q.ip_pend;
		st_d.ip_pend = st_q.g_v;
		if (st_q.ip_v) begin
			// Quarter-rate rotation: 0, 90, 180, 270 degrees
			yi = yv[0];
			yq = yv[1];
			unique case (st_q.mix_ph)
				2'h0: st_d.dac = {yq, yi};
				2'h1: st_d.dac = {yi, sat16(-17'sd1 * $signed(yq))};
				2'h2: st_d.dac = {sat16(-17'sd1 * $signed(yq)), sat16(-17'sd1 * $signed(yi))};
				2'h3: st_d.dac = {sat16(-17'sd1 * $signed(yi)), yq};
			endcase
			st_d.mix_ph = st_q.mix_ph + 2'h1;
			st_d.dac_v = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign sext_i = st_q.sext[0];
	assign sext_q = st_q.sext[1];
	assign sext_valid = st_q.sext_v;
	assign step_size = st_q.step;
	assign pwr_i = st_q.pwr[0];
	assign pwr_q = st_q.pwr[1];
	assign pwr_valid = st_q.pwr_v;
	assign dac_i = st_q.dac[0];
	assign dac_q = st_q.dac[1];
	assign dac_valid = st_q.dac_v;

	// Checks
	logic [WIN_LOG2+2:0] since_pwr;
	logic seen_pwr;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			since_pwr <= '0;
			seen_pwr <= 1'b0;
		end else if (pwr_valid) begin
			since_pwr <= '0;
			seen_pwr <= 1'b1;
		end else if (sext_valid) begin
			since_pwr <= since_pwr + 1'b1;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	property p_sext;
		sext_valid |-> (sext_i[15:11] == {5{sext_i[11]}}) && (sext_q[15:11] == {5{sext_q[11]}});
	endproperty
	a_sext: assert property (p_sext) else $error("sample not sign extended");

	property p_deser;
		(&word_v) |=> sext_valid && sext_i[11:0] == $past(word[0]) && sext_q[11:0] == $past(word[1]);
	endproperty
	a_deser: assert property (p_deser) else $error("word not forwarded");

	property p_gain_unity;
		cor_valid && gain_idx == rx_fe_pkg::GAIN_IDX_0DB |=> st_q.g[0] == $past(cor_i);
	endproperty
	a_gain_unity: assert property (p_gain_unity) else $error("0 dB gain altered sample");

	property p_gain_max;
		cor_valid && gain_idx == rx_fe_pkg::GAIN_IDX_MAX && cor_i == 16'h0400
			|=> st_q.g[0] == 16'h1FC6;
	endproperty
	a_gain_max: assert property (p_gain_max) else $error("18 dB gain wrong");

	property p_interp;
		st_q.g_v |=> st_q.ip_v ##1 st_q.ip_v;
	endproperty
	a_interp: assert property (p_interp) else $error("interpolation missed a sample");

	property p_dac;
		st_q.ip_v |=> dac_valid;
	endproperty
	a_dac: assert property (p_dac) else $error("mixer output missing");

	property p_refresh;
		pwr_valid && seen_pwr |-> since_pwr == (WIN_LOG2+3)'((1 << WIN_LOG2) * 4);
	endproperty
	a_refresh: assert property (p_refresh) else $error("power refresh interval wrong");

	property p_acc_start;
		sext_valid && st_q.wcnt == '0 |=> st_q.acc[0] == ACC_W'(square($past(sext_i)));
	endproperty
	a_acc_start: assert property (p_acc_start) else $error("window start not reloaded");

	property p_step_low;
		pwr_valid && ((34'(pwr_i) + 34'(pwr_q)) >> 1) < 34'($past(thr_low))
			|-> step_size == rx_fe_pkg::STEP_TBL[0];
	endproperty
	a_step_low: assert property (p_step_low) else $error("step size not from power");

	c_pwr: cover property (pwr_valid);
	c_dac: cover property (dac_valid ##1 dac_valid);
	c_gain: cover property (cor_valid && gain_idx == rx_fe_pkg::GAIN_IDX_11P5DB);
endmodule : rx_front_end

// *** rtl/rx_fe_pkg.sv ***
package rx_fe_pkg;
	localparam int SAMPLE_W = 12;
	localparam int DATA_W = 16;
	localparam int BITCNT_W = 4;
	localparam int NUM_CH = 2;
	localparam int GAIN_FRAC = 12;
	localparam int GAIN_STEPS = 43;
	localparam int GAIN_IDX_W = 6;
	localparam logic [5:0] GAIN_IDX_0DB = 6'h06;
	localparam logic [5:0] GAIN_IDX_11P5DB = 6'h1D;
	localparam logic [5:0] GAIN_IDX_MAX = 6'h2A;
	// Linear gain, 4.12 fixed point, -3 dB to +18 dB in 0.5 dB steps
	localparam logic [15:0] GAIN_LUT [GAIN_STEPS] = '{
		16'h0B54, 16'h0C00, 16'h0CB6, 16'h0D76, 16'h0E43, 16'h0F1B, 16'h1000, 16'h10F3,
		16'h11F4, 16'h1304, 16'h1425, 16'h1556, 16'h169A, 16'h17F1, 16'h195C, 16'h1ADC,
		16'h1C74, 16'h1E23, 16'h1FED, 16'h21D1, 16'h23D2, 16'h25F1, 16'h2831, 16'h2A92,
		16'h2D18, 16'h2FC4, 16'h3299, 16'h3598, 16'h38C5, 16'h3C22, 16'h3FB2, 16'h4379,
		16'h4778, 16'h4BB4, 16'h5031, 16'h54F1, 16'h59FA, 16'h5F4E, 16'h64F4, 16'h6AEF,
		16'h7146, 16'h77FC, 16'h7F18};
	localparam int WIN_LOG2_DEF = 19;
	localparam int WIN_SLOTS = 4;
	localparam logic [1:0] LAST_SLOT = 2'h3;
	localparam int PWR_W = 32;
	localparam int DC_SHIFT = 8;
	localparam int STEP_W = 4;
	// Step size code per power band, lowest band first
	localparam logic [3:0] STEP_TBL [WIN_SLOTS] = '{4'h8, 4'h6, 4'h4, 4'h2};
endpackage : rx_fe_pkg

// *** rtl/ser_word_capture.sv ***
`timescale 1ns/1ps
module ser_word_capture (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic bit_valid,
	input wire logic frame,
	input wire logic ser_bit,
	output logic [rx_fe_pkg::SAMPLE_W-1:0] word,
	output logic word_valid
);
	typedef struct packed {
		logic [rx_fe_pkg::SAMPLE_W-1:0] sh;
		logic [rx_fe_pkg::BITCNT_W-1:0] cnt;
		logic [rx_fe_pkg::SAMPLE_W-1:0] word;
		logic wv;
	} cap_t;

	cap_t cap_q;
	cap_t cap_d;

	// Frame marks the MSB; the word is out after the twelfth bit
	always_comb begin
		cap_d = cap_q;
		cap_d.wv = 1'b0;
		if (bit_valid) begin
			if (frame) begin
				cap_d.sh = {{(rx_fe_pkg::SAMPLE_W-1){1'b0}}, ser_bit};
				cap_d.cnt = 4'h1;
			end else if (cap_q.cnt != 4'h0) begin
				cap_d.sh = {cap_q.sh[rx_fe_pkg::SAMPLE_W-2:0], ser_bit};
				cap_d.cnt = cap_q.cnt + 4'h1;
				if (cap_q.cnt == 4'(rx_fe_pkg::SAMPLE_W - 1)) begin
					cap_d.word = {cap_q.sh[rx_fe_pkg::SAMPLE_W-2:0], ser_bit};
					cap_d.wv = 1'b1;
					cap_d.cnt = 4'h0;
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cap_q <= '0;
		end else begin
			cap_q <= cap_d;
		end
	end

	assign word = cap_q.word;
	assign word_valid = cap_q.wv;
endmodule : ser_word_capture

// *** sim/adc_serial_model.sv ***
`timescale 1ns/1ps
module adc_serial_model (
	input wire logic core_clk,
	output logic bit_valid,
	output logic frame,
	output logic bit_i,
	output logic bit_q
);
	initial begin
		bit_valid = 1'b0;
		frame = 1'b0;
		bit_i = 1'b0;
		bit_q = 1'b1;
	end
	// Released lines invert their last value on every idle cycle
	task automatic idle();
		bit_valid = 1'b0;
		frame = 1'b0;
		bit_i = ~bit_i;
		bit_q = ~bit_q;
	endtask : idle
	// One I/Q word pair, gap idle cycles between bits, none after the last
	task automatic send(input logic [11:0] wi, input logic [11:0] wq, input int gap);
		for (int b = 11; b >= 0; b--) begin
			bit_valid = 1'b1;
			frame = (b == 11);
			bit_i = wi[b];
			bit_q = wq[b];
			@(posedge core_clk);
			#1;
			repeat ((b == 0) ? 0 : gap) begin
				idle();
				@(posedge core_clk);
				#1;
			end
		end
		idle();
	endtask : send
endmodule : adc_serial_model

// *** sim/rx_front_end_tb_top.sv ***
`timescale 1ns/1ps
module rx_front_end_tb_top;
	localparam int WL = 3;
	logic core_clk, arst_n, adc_bit_valid, adc_frame, adc_bit_i, adc_bit_q;
	logic [15:0] sext_i, sext_q, cor_i, cor_q, dac_i, dac_q;
	logic sext_valid, cor_valid, pwr_valid, dac_valid;
	logic [5:0] gain_idx;
	logic [31:0] thr_low, thr_mid, thr_high, pwr_i, pwr_q;
	logic [3:0] step_size;
	int failures = 0;
	int check_count = 0;
	int cyc = 0;
	int pv_cnt = 0;

	adc_serial_model adc (.core_clk(core_clk), .bit_valid(adc_bit_valid), .frame(adc_frame),
		.bit_i(adc_bit_i), .bit_q(adc_bit_q));
	rx_front_end #(.WIN_LOG2(WL)) uut (.core_clk(core_clk), .arst_n(arst_n),
		.adc_bit_valid(adc_bit_valid), .adc_frame(adc_frame), .adc_bit_i(adc_bit_i),
		.adc_bit_q(adc_bit_q), .sext_i(sext_i), .sext_q(sext_q), .sext_valid(sext_valid),
		.cor_i(cor_i), .cor_q(cor_q), .cor_valid(cor_valid), .gain_idx(gain_idx),
		.thr_low(thr_low), .thr_mid(thr_mid), .thr_high(thr_high), .step_size(step_size),
		.pwr_i(pwr_i), .pwr_q(pwr_q), .pwr_valid(pwr_valid), .dac_i(dac_i), .dac_q(dac_q),
		.dac_valid(dac_valid));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic results();
		if (failures == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : results

	always @(posedge core_clk) begin
		cyc++;
		if (pwr_valid === 1'b1) begin
			pv_cnt++;
		end
		if (cyc == 20000) begin
			failures++;
			results();
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %0h seen %0h", name, exp, got);
		end
	endtask : chk

	task automatic do_reset();
		arst_n = 1'b0;
		repeat (10) @(posedge core_clk);
		#1;
		arst_n = 1'b1;
	endtask : do_reset

	task automatic t_sext();
		logic [11:0] wi [3] = '{12'h800, 12'h7FF, 12'hA5C};
		logic [11:0] wq [3] = '{12'h7FF, 12'h800, 12'h123};
		for (int n = 0; n < 3; n++) begin
			adc.send(wi[n], wq[n], n);
			@(posedge core_clk);
			#1;
			chk("sext_valid", 32'h1, {31'h0, sext_valid});
			chk("sext_i", {16'h0, {4{wi[n][11]}}, wi[n]}, {16'h0, sext_i});
			chk("sext_q", {16'h0, {4{wq[n][11]}}, wq[n]}, {16'h0, sext_q});
		end
	endtask : t_sext

	task automatic t_power();
		logic [31:0] thr [3][3] = '{'{32'h9000, 32'h9100, 32'h9200},
			'{32'h100, 32'h9000, 32'h9100}, '{32'h100, 32'h200, 32'h300}};
		logic [3:0] stp [3] = '{4'h8, 4'h6, 4'h2};
		for (int c = 0; c < 3; c++) begin
			do_reset();
			thr_low = thr[c][0];
			thr_mid = thr[c][1];
			thr_high = thr[c][2];
			pv_cnt = 0;
			// Last case runs two refresh periods so the interval check is reached
			repeat ((c == 2 ? 8 : 4) << WL) adc.send(12'h100, 12'hFC0, 0);
			repeat (2) @(posedge core_clk);
			#1;
			chk("pwr_early", (c == 2) ? 32'h1 : 32'h0, pv_cnt);
			chk("pwr_valid", 32'h1, {31'h0, pwr_valid});
			chk("pwr_i", 32'h10000, pwr_i);
			chk("pwr_q", 32'h1000, pwr_q);
			chk("step_size", {28'h0, stp[c]}, {28'h0, step_size});
		end
	endtask : t_power

	task automatic t_gain();
		logic [5:0] idx [5] = '{6'h00, rx_fe_pkg::GAIN_IDX_0DB, rx_fe_pkg::GAIN_IDX_11P5DB,
			rx_fe_pkg::GAIN_IDX_MAX, 6'h3F};
		logic [15:0] g;
		logic [15:0] h;
		for (int k = 0; k < 5; k++) begin
			do_reset();
			gain_idx = idx[k];
			g = rx_fe_pkg::GAIN_LUT[(idx[k] > 6'h2A) ? 6'h2A : idx[k]] >> 2;
			h = g >> 1;
			cor_i = 16'h0400;
			cor_q = 16'h0000;
			cor_valid = 1'b1;
			@(posedge core_clk);
			#1;
			cor_valid = 1'b0;
			repeat (2) @(posedge core_clk);
			#1;
			chk("dac_valid_mid", 32'h1, {31'h0, dac_valid});
			chk("dac_i_mid", {16'h0, h}, {16'h0, dac_i});
			chk("dac_q_mid", 32'h0, {16'h0, dac_q});
			@(posedge core_clk);
			#1;
			chk("dac_valid_cur", 32'h1, {31'h0, dac_valid});
			chk("dac_i_cur", 32'h0, {16'h0, dac_i});
			chk("dac_q_cur", {16'h0, g - (h >> 8)}, {16'h0, dac_q});
		end
	endtask : t_gain

	initial begin
		arst_n = 1'b0;
		cor_i = 16'h0000;
		cor_q = 16'h0000;
		cor_valid = 1'b0;
		gain_idx = rx_fe_pkg::GAIN_IDX_0DB;
		thr_low = 32'h0;
		thr_mid = 32'h0;
		thr_high = 32'h0;
		#1;
		do_reset();
		t_sext();
		t_power();
		t_gain();
		results();
	end
endmodule : rx_front_end_tb_top
